/* dv/sase_exec_checker.sv */
// Assertion checker for the ALU/shift executer
`timescale 1ns/1ns
module sase_exec_checker #(parameter W = 16) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire instr_valid_in,
	input wire [15:0] instr_in,
	input wire [W-1:0] pstk_rdata_in,
	input wire pstk_push_out,
	input wire pstk_pop_out,
	input wire [W-1:0] pstk_wdata_out,
	input wire [W-1:0] top_out,
	input wire [W-1:0] nxt_out,
	input wire carry_flag_out,
	input wire ret_req_out,
	input wire idle_instruction_out,
	input wire class_hit_out
);
	wire ex = instr_valid_in && instr_in[15:12] == 4'ha;
	wire po = ex && instr_in[7:6] == 2'h1;
	wire du = ex && instr_in[7:6] == 2'h2;
	wire pu = ex && instr_in[7:6] == 2'h3;
	wire [2:0] fa = instr_in[11:9];
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	property p_hit; class_hit_out == $past(ex); endproperty
	a_hit: assert property (p_hit) else $error("hit");
	property p_idle; ex && instr_in[11:6] == 0 && instr_in[3:0] == 0
		|=> idle_instruction_out &&
		$stable({top_out, nxt_out, carry_flag_out}); endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_push; pu |=> pstk_push_out && !pstk_pop_out &&
		pstk_wdata_out == $past(nxt_out) && nxt_out == $past(top_out);
	endproperty
	a_push: assert property (p_push) else $error("push");
	property p_pop; po |=> pstk_pop_out && nxt_out == $past(pstk_rdata_in);
	endproperty
	a_pop: assert property (p_pop) else $error("pop");
	property p_dup; du |=> nxt_out == $past(top_out) && !pstk_push_out;
	endproperty
	a_dup: assert property (p_dup) else $error("dup");
	property p_off; !ex |=> $stable({top_out, nxt_out}) && !class_hit_out;
	endproperty
	a_off: assert property (p_off) else $error("off");
	property p_bool; ex && (fa == 1 || fa == 3 || fa == 5) &&
		instr_in[2:1] == 0
		|=> $stable(carry_flag_out); endproperty
	a_bool: assert property (p_bool) else $error("carry");
	property p_top; ex && instr_in[7:6] == 0 && !instr_in[3]
		|=> $stable(nxt_out); endproperty
	a_top: assert property (p_top) else $error("next");
	c_pop: cover property (po);
	c_push: cover property (pu);
	c_dup: cover property (du);
endmodule
bind sase_exec sase_exec_checker #(.W(W)) chk_i (.*);

/* dv/sase_pstk_model.sv */
// Parameter stack memory model facing the executer
`timescale 1ns/1ns
module sase_pstk_model (
	input wire clk_sys_in,
	input wire rst_in,
	input wire push_in,
	input wire pop_in,
	input wire [15:0] wdata_in,
	output wire [15:0] rdata_out
);
	reg [15:0] mem_reg [0:255];
	reg [15:0] junk_reg;
	reg [7:0] sp_reg;
	wire [7:0] sp = sp_reg - pop_in;
	// A pending pulse counts as done, so back-to-back pops see the new top
	assign rdata_out = push_in ? wdata_in :
		(sp != 8'h0) ? mem_reg[sp - 8'h1] : junk_reg;
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sp_reg <= 8'h0;
			junk_reg <= 16'h5a3c;
		end else begin
			// Empty stack shows a word that changes every cycle
			junk_reg <= ~junk_reg + 16'h1;
			if (push_in)
				mem_reg[sp_reg] <= wdata_in;
			sp_reg <= sp_reg + push_in - pop_in;
		end
	end
endmodule

/* dv/stack_alu_shift_instr_exec_tb_top.sv */
// Self-checking bench for the ALU/shift executer
`timescale 1ns/1ns
module stack_alu_shift_instr_exec_tb_top;
	reg clk_sys_in = 0;
	reg rst_in = 1;
	reg instr_valid_in = 0;
	reg [15:0] instr_in = 0;
	wire [15:0] rd, wd, top_out, nxt_out;
	wire [5:0] fl;
	reg [15:0] t, n, q[$];
	reg c;
	reg [31:0] x;
	reg [32:0] d;
	integer err_count = 0, comparisons = 0, j;
	always #20 clk_sys_in = ~clk_sys_in;
	sase_pstk_model mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.push_in(fl[2]), .pop_in(fl[1]), .wdata_in(wd), .rdata_out(rd));
	sase_exec dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.pstk_rdata_in(rd), .pstk_push_out(fl[2]), .pstk_pop_out(fl[1]),
		.pstk_wdata_out(wd), .top_out(top_out), .nxt_out(nxt_out),
		.carry_flag_out(fl[5]), .ret_req_out(fl[4]),
		.idle_instruction_out(fl[3]), .class_hit_out(fl[0]));
	task chk(input [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("mismatch at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task results;
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task step(input [15:0] w, input v);
		reg [16:0] r;
		reg [15:0] m, p;
		reg [5:0] e;
		reg a, b;
		begin
		// Stack depth stays within the memory model
		if (w[7:6] == 1 && q.size() == 0) w[7:6] = 3;
		if (w[7:6] == 3 && q.size() > 250) w[7:6] = 1;
		instr_in = w;
		instr_valid_in = v;
		e = {c, 5'h0};
		m = n;
		p = t;
		if (v && w[15:12] == 4'ha) begin
			r = {c, w[11:9] == 7 ? n : t};
			case (w[11:9])
			0, 7: r[15:0] = r[15:0] ^ {16{w[8]}};
			1: r[15:0] = w[8] ? ~(t | n) : t & n;
			2: r = {1'b0, n} + {1'b0, ~t} + (w[8] ? c : 1'b1);
			3: r[15:0] = t | n;
			4: r = t + n + (w[8] & c);
			5: r[15:0] = w[8] ? ~(t ^ n) : t ^ n;
			6: r = {1'b0, t} + {1'b0, ~n} + (w[8] ? c : 1'b1);
			endcase
			d = {r, n};
			a = w[0] & r[16];
			case (w[3:0])
			0: ;
			1: d[31:16] = {16{d[31]}};
			2, 3, 10, 11: d = w[3] ? {d[31:0], a} : {d[31:16], a, n};
			8, 9: d[15:0] = {n[14:0], a};
			default: begin
				a = w[0] & d[31];
				b = w[0] & (w[3] ? d[0] : d[16]);
				d = {w[1] ? a : b, w[1] ? a : d[32],
					w[3] ? d[31:1] : {d[31:17], n}};
			end
			endcase
			{c, t, n} = d;
			if (w[7:6] == 1) n = q.pop_back();
			if (w[7:6] > 1) n = p;
			if (w[7:6] == 3) q.push_back(m);
			e = {c, w[5], w[11:6] == 0 && w[3:0] == 0, w[7:6] == 3,
				w[7:6] == 1, 1'b1};
		end
		@(negedge clk_sys_in);
		chk(top_out, t);
		chk(nxt_out, n);
		chk({10'h0, fl}, {10'h0, e});
		if (e[2]) chk(wd, m);
		end
	endtask
	initial begin
		x = $urandom(27);
		repeat (3) @(negedge clk_sys_in);
		rst_in = 0;
		{t, n, c} = 0;
		chk(top_out | nxt_out | fl, 16'h0);
		step(16'ha000, 1);
		step(16'ha020, 1);
		step(16'ha102, 1);
		for (j = 0; j < 600; j++) begin
			x = $urandom;
			step({x[20] | x[21] ? 4'ha : 4'h9, x[11:8],
				x[7:5], 1'b0, x[3:0]}, x[31:29] != 0);
		end
		results;
	end
endmodule

/* src/sase_alu.v */
// Two-operand ALU of the ALU/shift instruction class
`timescale 1ns/1ns
`include "sase_map.vh"
module sase_alu #(
	parameter W = 16
) (
	// Operands and function code
	input wire [W-1:0] top_in,
	input wire [W-1:0] nxt_in,
	input wire [3:0] fn_in,
	input wire carry_in,
	// Result
	output reg [W-1:0] res_out,
	output reg carry_out,
	output reg carry_upd_out
);
	reg [W:0] sum;
	reg cin;
	always @* begin
		sum = {(W+1){1'b0}};
		cin = fn_in[0] ? carry_in : 1'b1;
		res_out = {W{1'b0}};
		carry_out = carry_in;
		carry_upd_out = 1'b0;
		// RL15 carry use
		case (fn_in[3:1])
		`SASE_ALU_AND: res_out = fn_in[0] ? ~(top_in | nxt_in) : top_in & nxt_in;
		`SASE_ALU_NSUB: begin
			sum = {1'b0, nxt_in} + {1'b0, ~top_in} + {{W{1'b0}}, cin};
			res_out = sum[W-1:0];
			carry_out = sum[W];
			carry_upd_out = 1'b1;
		end
		`SASE_ALU_OR: res_out = top_in | nxt_in;
		`SASE_ALU_ADD: begin
			sum = {1'b0, top_in} + {1'b0, nxt_in} +
				{{W{1'b0}}, fn_in[0] & carry_in};
			res_out = sum[W-1:0];
			carry_out = sum[W];
			carry_upd_out = 1'b1;
		end
		`SASE_ALU_XOR: res_out = fn_in[0] ? ~(top_in ^ nxt_in) : top_in ^ nxt_in;
		`SASE_ALU_SUB: begin
			sum = {1'b0, top_in} + {1'b0, ~nxt_in} + {{W{1'b0}}, cin};
			res_out = sum[W-1:0];
			carry_out = sum[W];
			carry_upd_out = 1'b1;
		end
		default: res_out = top_in;
		endcase
	end
endmodule

/* src/sase_exec.v */
// Single-cycle ALU/shift instruction executer with top and second registers
`timescale 1ns/1ns
`include "sase_map.vh"
module sase_exec #(
	parameter W = 16
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// Instruction
	input wire instr_valid_in,
	input wire [15:0] instr_in,
	// Parameter stack memory
	input wire [W-1:0] pstk_rdata_in,
	output reg pstk_push_out,
	output reg pstk_pop_out,
	output reg [W-1:0] pstk_wdata_out,
	// Architectural state and status strobes
	output reg [W-1:0] top_out,
	output reg [W-1:0] nxt_out,
	output reg carry_flag_out,
	output reg ret_req_out,
	output reg idle_instruction_out,
	output reg class_hit_out
);
	reg [W-1:0] top_next;
	reg [W-1:0] nxt_next;
	reg carry_next;
	reg [W-1:0] a;
	reg [W-1:0] sn;
	reg c;
	wire [W-1:0] alu_res;
	wire alu_c;
	wire alu_upd;
	wire [3:0] fn = instr_in[`SASE_FN_HI:`SASE_FN_LO];
	wire [1:0] stk = instr_in[`SASE_STK_HI:`SASE_STK_LO];
	wire [3:0] sh = instr_in[`SASE_SH_HI:`SASE_SH_LO];
	// RL16 class decode
	wire hit = instr_valid_in &
		(instr_in[`SASE_CLS_HI:`SASE_CLS_LO] == `SASE_CLASS);
	wire single = (fn == `SASE_FN_INV0) | (fn == `SASE_FN_INV1);
	wire copy = (fn == `SASE_FN_CPY0) | (fn == `SASE_FN_CPY1);
	wire inv = fn[0];
	// RL2 idle instruction decode
	wire idle = (fn == `SASE_FN_INV0) & (stk == `SASE_STK_NONE) &
		(sh == `SASE_SH_NONE);
	reg pop_next;
	reg push_next;
	reg ret_next;
	reg idle_next;

	sase_alu #(.W(W)) u_alu (
		.top_in(top_out),
		.nxt_in(nxt_out),
		.fn_in(fn),
		.carry_in(carry_flag_out),
		.res_out(alu_res),
		.carry_out(alu_c),
		.carry_upd_out(alu_upd)
	);

	// Shifter on the selected operand and NEXT; returns {carry, top, next}
	// Carry in is the ALU carry for add/subtract, else the carry flag, so rotates chain multi-word arithmetic
	function [2*W:0] shift_step;
		input [3:0] code;
		input [W-1:0] z;
		input [W-1:0] low;
		input cy;
		reg [W-1:0] t;
		reg [W-1:0] s;
		reg k;
		begin
			t = z;
			s = low;
			k = cy;
			// RL14 shift scope
			case (code)
			`SASE_SH_NONE: begin
				t = z;
			end
			`SASE_SH_SIGN: begin
				t = {W{z[W-1]}};
			end
			`SASE_SH_SHL: begin
				t = {z[W-2:0], 1'b0};
				k = z[W-1];
			end
			`SASE_SH_ROL: begin
				t = {z[W-2:0], cy};
				k = z[W-1];
			end
			`SASE_SH_CUR: begin
				t = {cy, z[W-1:1]};
				k = 1'b0;
			end
			`SASE_SH_RRC: begin
				t = {cy, z[W-1:1]};
				k = z[0];
			end
			`SASE_SH_LSR: begin
				t = {1'b0, z[W-1:1]};
				k = 1'b0;
			end
			`SASE_SH_ASR: begin
				t = {z[W-1], z[W-1:1]};
				k = z[W-1];
			end
			`SASE_SH_NSHL: begin
				s = {low[W-2:0], 1'b0};
			end
			`SASE_SH_NROL: begin
				s = {low[W-2:0], cy};
			end
			`SASE_SH_DSHL: begin
				{k, t, s} = {z, low, 1'b0};
			end
			`SASE_SH_DROL: begin
				{k, t, s} = {z, low, cy};
			end
			`SASE_SH_DCUR: begin
				{t, s} = {cy, z, low[W-1:1]};
				k = 1'b0;
			end
			`SASE_SH_DRRC: begin
				{t, s, k} = {cy, z, low};
			end
			`SASE_SH_DLSR: begin
				{t, s} = {1'b0, z, low[W-1:1]};
				k = 1'b0;
			end
			default: begin
				{t, s} = {z[W-1], z, low[W-1:1]};
				k = z[W-1];
			end
			endcase
			shift_step = {k, t, s};
		end
	endfunction

	// Strobes for the stack memory and the sequencer, one cycle each
	always @* begin
		pop_next = 1'b0;
		push_next = 1'b0;
		ret_next = 1'b0;
		idle_next = 1'b0;
		if (hit) begin
			// RL5 RL6 RL7 pop strobe
			pop_next = (stk == `SASE_STK_POP);
			// RL11 RL12 push strobe
			push_next = (stk == `SASE_STK_PUSH);
			// RL17 return bit
			ret_next = instr_in[`SASE_RET_BIT];
			// RL2 idle instruction
			idle_next = idle;
		end
	end

	always @* begin
		a = top_out;
		sn = nxt_out;
		c = carry_flag_out;
		top_next = top_out;
		nxt_next = nxt_out;
		carry_next = carry_flag_out;
		// Select the value that feeds the shifter
		if (single) begin
			// RL1 invert top
			a = inv ? ~top_out : top_out;
		end else if (copy) begin
			// RL3 second to top
			a = inv ? ~nxt_out : nxt_out;
		end else begin
			// RL4 ALU result
			a = alu_res;
			c = alu_upd ? alu_c : carry_flag_out;
		end
		// Shifts always see the original second register
		{c, top_next, sn} = shift_step(sh, a, nxt_out, c);
		carry_next = c;
		// Stack movement on the second register
		case (stk)
		`SASE_STK_NONE: begin
			// RL1 RL3 RL4 second kept unless shifted
			nxt_next = sn;
		end
		`SASE_STK_POP: begin
			// RL5 RL6 RL7 pop after shift
			// The memory shows its top word; its pointer moves on the strobe
			nxt_next = pstk_rdata_in;
		end
		`SASE_STK_DUP: begin
			// RL8 RL9 RL10 old top to second
			nxt_next = top_out;
		end
		default: begin
			// RL11 RL12 old top to second
			nxt_next = top_out;
		end
		endcase
		// RL16 other classes and empty cycles keep all state
		if (!hit) begin
			top_next = top_out;
			nxt_next = nxt_out;
			carry_next = carry_flag_out;
		end
	end

	// RL13 one cycle
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			top_out <= `SASE_TOP_RST;
			nxt_out <= `SASE_NXT_RST;
			carry_flag_out <= 1'b0;
			pstk_push_out <= 1'b0;
			pstk_pop_out <= 1'b0;
			pstk_wdata_out <= {W{1'b0}};
			ret_req_out <= 1'b0;
			idle_instruction_out <= 1'b0;
			class_hit_out <= 1'b0;
		end else begin
			top_out <= top_next;
			nxt_out <= nxt_next;
			carry_flag_out <= carry_next;
			// RL11 RL12 old second goes out with the push strobe
			pstk_push_out <= push_next;
			pstk_pop_out <= pop_next;
			pstk_wdata_out <= nxt_out;
			ret_req_out <= ret_next;
			idle_instruction_out <= idle_next;
			class_hit_out <= hit;
		end
	end
endmodule

/* src/sase_map.vh */
// Constants for the stack ALU/shift instruction executer
// Overview of operation
// RL1 - Single-register form: optionally invert top, then shift; second kept unless shifted.
// RL2 - Invert flag zero with shift code zero is a one-cycle idle instruction; the code also requires function code zero and stack code zero.
// RL3 - Copy-from-second form: top gets second, optionally inverted, then shifted.
// RL4 - Two-operand form: shifted ALU result of top and second goes to top.
// RL5 - Pop single-register form: shift top with old second, then pop into second.
// RL6 - Pop copy form: second to top, invert, shift, then pop into second.
// RL7 - Pop two-operand form: shifted ALU result to top, pop into second.
// RL8 - Duplicate form: old top into second, then invert and shift top.
// RL9 - Exchange form: swap top and second, invert new top, then shift.
// RL10 - Two-operand copy form: shifted ALU result to top, old top to second.
// RL11 - Push-duplicate form: push second, top into second, invert and shift top.
// RL12 - Push-exchange form: push second, top to second, old second to top.
// RL13 - Every instruction of this class completes in one clock cycle.
// RL14 - First eight shift codes touch top only; others touch second or both.
// RL15 - Boolean functions leave carry alone; add/subtract set it; only add-with-carry and borrow forms use it.
// RL16 - Class by top four bits; function 11:8, stack code 7:6, shift 3:0.
// RL17 - Bit 5 is decoded as a parallel subroutine return request.
`ifndef SASE_MAP_VH
`define SASE_MAP_VH
`define SASE_CLASS 4'ha
`define SASE_CLS_HI 15
`define SASE_CLS_LO 12
`define SASE_FN_HI 11
`define SASE_FN_LO 8
`define SASE_STK_HI 7
`define SASE_STK_LO 6
`define SASE_RET_BIT 5
`define SASE_SH_HI 3
`define SASE_SH_LO 0
`define SASE_FN_INV0 4'h0
`define SASE_FN_INV1 4'h1
`define SASE_FN_CPY0 4'he
`define SASE_FN_CPY1 4'hf
`define SASE_STK_NONE 2'h0
`define SASE_STK_POP 2'h1
`define SASE_STK_DUP 2'h2
`define SASE_STK_PUSH 2'h3
`define SASE_SH_NONE 4'h0
`define SASE_SH_SIGN 4'h1
`define SASE_SH_SHL 4'h2
`define SASE_SH_ROL 4'h3
`define SASE_SH_CUR 4'h4
`define SASE_SH_RRC 4'h5
`define SASE_SH_LSR 4'h6
`define SASE_SH_ASR 4'h7
`define SASE_SH_NSHL 4'h8
`define SASE_SH_NROL 4'h9
`define SASE_SH_DSHL 4'ha
`define SASE_SH_DROL 4'hb
`define SASE_SH_DCUR 4'hc
`define SASE_SH_DRRC 4'hd
`define SASE_SH_DLSR 4'he
`define SASE_SH_DASR 4'hf
`define SASE_ALU_AND 3'h1
`define SASE_ALU_NOR 3'h1
`define SASE_ALU_NSUB 3'h2
`define SASE_ALU_OR 3'h3
`define SASE_ALU_ADD 3'h4
`define SASE_ALU_XOR 3'h5
`define SASE_ALU_SUB 3'h6
`define SASE_TOP_RST 16'h0000
`define SASE_NXT_RST 16'h0000
`endif
